/* File: rtl/fpm_mapper.sv */
/*
 cyclic process-data mapper for a fieldbus i/o device: one communicator
 slot and eight pyrometer slots, with parameter decode and diagnostics.
 assumes an ahb-lite master on hclk, single word transfers, and sensor-side
 logic that feeds temperatures and communication-fail levels synchronously.
*/
`timescale 1ns/1ps

module fpm_mapper
   import fpm_pkg::*;
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output fpm_ahb_rsp_t                 ahb_rsp,
   input  wire logic                    trigger_in,
   input  wire logic [31:0]             station_temp,
   input  fpm_temp_t [NUM_MOD-1:0]      mod_temp,
   input  wire logic [NUM_MOD-1:0]      mod_comm_fail,
   input  wire logic [NUM_MOD-1:0]      mod_ext_err,
   output fpm_param_t [NUM_MOD-1:0]     mod_param,
   output logic [NUM_MOD-1:0]           param_upd,
   output logic                         problem_ind,
   output logic                         diag_alarm,
   output logic                         station_problem
);

   // bus data-phase state
   logic                  dp_valid;
   logic                  dp_write;
   logic [11:0]           dp_addr;

   // control and parameter state
   logic                  dx_mode;
   logic                  hold_on_fault;
   logic                  periph_diag_en;
   logic [NUM_MOD-1:0]    diag_en;
   logic [NUM_MOD-1:0]    chan_err;
   logic [NUM_MOD-1:0]    fail_q;
   logic [NUM_MOD-1:0]    alarm_lat;
   fpm_temp_t [NUM_MOD-1:0] pd;
   logic [7:0]            comm_diag;
   logic [31:0]           station_pd;
   logic [7:0]            trig_byte;
   logic [31:0]           next_rdata;
   logic [11:0]           rd_addr;
   logic [7:0]            iops [NUM_MOD];

   logic [NUM_MOD-1:0]    out_we;
   logic [NUM_MOD-1:0]    fwd_fail;

   // decode: is address inside module window, which slot
   function automatic logic in_mod(input logic [11:0] a);
      in_mod = (a >= OFS_MOD_BASE) && (a < OFS_MOD_BASE + 12'(NUM_MOD) * MOD_STRIDE);
   endfunction

   function automatic logic [2:0] mod_idx(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - OFS_MOD_BASE;
      mod_idx = rel[7:5];
   endfunction

   // address phase capture; slave is always ready, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 12'h000;
      end else if (hready) begin
         dp_valid <= hsel && htrans[1];
         dp_write <= hwrite;
         dp_addr  <= {haddr[11:2], 2'b00};
      end
   end

   // controller output frame written in one word: {8'h0, sel, value hi, value lo}
   always_comb begin
      for (int i = 0; i < NUM_MOD; i++) begin
         out_we[i] = dp_valid && dp_write && in_mod(dp_addr)
                     && (mod_idx(dp_addr) == 3'(i))
                     && (dp_addr[4:0] == SUB_OUT);
      end
   end

   // control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dx_mode        <= 1'b0;
         hold_on_fault  <= 1'b0;
         periph_diag_en <= 1'b0;
         diag_en        <= '0;
      end else if (dp_valid && dp_write) begin
         if (dp_addr == OFS_CTRL) begin
            dx_mode        <= hwdata[CTRL_DX_BIT];
            hold_on_fault  <= hwdata[CTRL_HOLD_BIT];
            periph_diag_en <= hwdata[CTRL_PDIAG_BIT];
         end
         if (dp_addr == OFS_DIAG_EN)
            diag_en <= hwdata[NUM_MOD-1:0];
      end
   end

   // per-module parameter decode and update
   generate
      for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
         logic [7:0]  sel;
         logic [15:0] val;
         assign sel = hwdata[23:16];
         assign val = {hwdata[15:8], hwdata[7:0]};

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               mod_param[g] <= '{emis: RST_EMIS, laser: 2'b00, bg: RST_BG,
                                 avg: 16'h0000, peak: 16'h0000,
                                 valley: 16'h0000, setpt: RST_SETPT};
               param_upd[g] <= 1'b0;
            end else begin
               param_upd[g] <= 1'b0;
               // frames outside data exchange or with selector 0 change no parameter
               if (out_we[g] && dx_mode && sel != SEL_IGNORE) begin
                  case (sel)
                     SEL_EMIS: begin
                        if (val >= EMIS_MIN && val <= EMIS_MAX) begin
                           mod_param[g].emis <= val;
                           param_upd[g]      <= 1'b1;
                        end
                     end
                     SEL_LASER: begin
                        if (val == LASER_OFF || val == LASER_ON || val == LASER_FLASH) begin
                           mod_param[g].laser <= val[1:0];
                           param_upd[g]       <= 1'b1;
                        end
                     end
                     SEL_BG: begin
                        mod_param[g].bg <= val;
                        param_upd[g]    <= 1'b1;
                     end
                     SEL_AVG: begin
                        mod_param[g].avg <= val;
                        param_upd[g]     <= 1'b1;
                     end
                     SEL_PEAK: begin
                        mod_param[g].peak <= val;
                        param_upd[g]      <= 1'b1;
                     end
                     SEL_VALLEY: begin
                        mod_param[g].valley <= val;
                        param_upd[g]        <= 1'b1;
                     end
                     SEL_SETPT: begin
                        mod_param[g].setpt <= val;
                        param_upd[g]       <= 1'b1;
                     end
                     default: begin
                        param_upd[g] <= 1'b0;                       // unknown selector dropped
                     end
                  endcase
               end
            end
         end

         // process data image: zero or hold on fault
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pd[g] <= '0;
            end else if (mod_comm_fail[g]) begin
               if (!hold_on_fault)
                  pd[g] <= '0;
            end else begin
               pd[g] <= mod_temp[g];
            end
         end
      end
   endgenerate

   // station frame: trigger byte, then temperature
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_byte  <= 8'h00;
         station_pd <= 32'h0000_0000;
      end else begin
         trig_byte  <= {7'h00, trigger_in};
         station_pd <= station_temp;
      end
   end

   // diagnostics: fail history, channel errors, alarms
   assign fwd_fail = mod_comm_fail & diag_en;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fail_q    <= '0;
         chan_err  <= '0;
         alarm_lat <= '0;
      end else begin
         fail_q <= mod_comm_fail;
         // sticky; set wins over a software clear in the same cycle
         for (int i = 0; i < NUM_MOD; i++) begin
            if ((mod_ext_err[i] && diag_en[i]) ||
                (out_we[i] && !dx_mode && hwdata[23:16] != SEL_IGNORE))
               chan_err[i] <= 1'b1;
            else if (dp_valid && dp_write && dp_addr == OFS_CHAN_ERR && hwdata[i])
               chan_err[i] <= 1'b0;
         end
         alarm_lat <= fwd_fail & ~fail_q;
      end
   end

   // communicator diagnosis byte and frame-level indications
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comm_diag       <= 8'h00;
         problem_ind     <= 1'b0;
         diag_alarm      <= 1'b0;
         station_problem <= 1'b0;
      end else begin
         comm_diag                <= 8'h00;
         comm_diag[COMM_DIAG_BIT] <= |mod_comm_fail;
         problem_ind     <= |fwd_fail;
         // one-cycle alarm pulse on each new forwarded fault, only while periph_diag_en is set
         diag_alarm      <= periph_diag_en && (|(fwd_fail & ~fail_q));
         station_problem <= |(fwd_fail & ~fail_q);
      end
   end

   // read address taken in the address phase so read data can be registered
   assign rd_addr = {haddr[11:2], 2'b00};

   // read mux; big-endian words as the controller sees them
   always_comb begin
      logic [2:0] mi;
      mi         = mod_idx(rd_addr);
      next_rdata = 32'h0000_0000;
      if (in_mod(rd_addr)) begin
         case (rd_addr[4:0])
            SUB_OBJ:      next_rdata = pd[mi].obj;
            SUB_INT:      next_rdata = pd[mi].intern;
            SUB_EMIS:     next_rdata = {16'h0000, mod_param[mi].emis};
            SUB_LASER_BG: next_rdata = {14'h0000, mod_param[mi].laser, mod_param[mi].bg};
            SUB_AVG_PEAK: next_rdata = {mod_param[mi].avg, mod_param[mi].peak};
            SUB_VAL_SP:   next_rdata = {mod_param[mi].valley, mod_param[mi].setpt};
            SUB_DIAG:     next_rdata = {24'h00_0000, 1'b0,
                                        mod_comm_fail[mi] && diag_en[mi], 6'h00};
            default:      next_rdata = 32'h0000_0000;
         endcase
      end else begin
         case (rd_addr)
            OFS_CTRL:      next_rdata = {29'h0, periph_diag_en, hold_on_fault, dx_mode};
            OFS_STATUS:    next_rdata = {30'h0, station_problem, problem_ind};
            OFS_COMM_TEMP: next_rdata = station_pd;
            OFS_DIAG_EN:   next_rdata = {24'h0, diag_en};
            OFS_MOD_FAIL:  next_rdata = {24'h0, mod_comm_fail};
            OFS_CHAN_ERR:  next_rdata = {24'h0, chan_err};
            OFS_COMM_DIAG: next_rdata = {24'h0, comm_diag};
            OFS_COMM_W0:   next_rdata = {trig_byte, station_pd[31:8]};
            OFS_COMM_W1:   next_rdata = {station_pd[7:0], 24'h00_0000};
            OFS_IOPS:      next_rdata = {iops[3], iops[2], iops[1], iops[0]};
            OFS_IOPS_HI:   next_rdata = {iops[7], iops[6], iops[5], iops[4]};
            default:       next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // qualifier bytes for all eight slots, four per word
   always_comb begin
      for (int i = 0; i < NUM_MOD; i++)
         iops[i] = mod_comm_fail[i] ? IOPS_BAD : IOPS_GOOD;
   end

   // read data captured at the address phase, stands through the data phase;
   // limitation: a read right behind a write to the same word sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ahb_rsp <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
      end else begin
         ahb_rsp.hreadyout <= 1'b1;                                 // zero wait states
         ahb_rsp.hresp     <= 1'b0;                                 // always okay
         if (hready && hsel && htrans[1] && !hwrite)
            ahb_rsp.hrdata <= next_rdata;
      end
   end

endmodule // fpm_mapper

/* File: rtl/fpm_pkg.sv */
/*
 package for the process-data mapper: register map, field layout, reset
 values, parameter selectors and the carriers that group related signals.
 assumes nothing beyond a synthesizable SystemVerilog tool flow.
*/
package fpm_pkg;

   localparam int          NUM_MOD        = 8;
   localparam int          COMM_IN_BYTES  = 5;
   localparam int          MOD_IN_BYTES   = 8;
   localparam int          MOD_OUT_BYTES  = 3;

   // register byte addresses
   localparam logic [11:0] OFS_CTRL       = 12'h000;
   localparam logic [11:0] OFS_STATUS     = 12'h004;
   localparam logic [11:0] OFS_COMM_TEMP  = 12'h008;
   localparam logic [11:0] OFS_DIAG_EN    = 12'h00c;
   localparam logic [11:0] OFS_MOD_FAIL   = 12'h010;
   localparam logic [11:0] OFS_CHAN_ERR   = 12'h014;
   localparam logic [11:0] OFS_COMM_DIAG  = 12'h018;
   localparam logic [11:0] OFS_COMM_W0    = 12'h01c;
   localparam logic [11:0] OFS_COMM_W1    = 12'h020;
   localparam logic [11:0] OFS_IOPS       = 12'h024;
   localparam logic [11:0] OFS_IOPS_HI    = 12'h028;
   localparam logic [11:0] OFS_MOD_BASE   = 12'h100;
   localparam logic [11:0] MOD_STRIDE     = 12'h020;
   // per-module sub-offsets
   localparam logic [4:0]  SUB_OBJ        = 5'h00;
   localparam logic [4:0]  SUB_INT        = 5'h04;
   localparam logic [4:0]  SUB_OUT        = 5'h08;
   localparam logic [4:0]  SUB_EMIS       = 5'h0c;
   localparam logic [4:0]  SUB_LASER_BG   = 5'h10;
   localparam logic [4:0]  SUB_AVG_PEAK   = 5'h14;
   localparam logic [4:0]  SUB_VAL_SP     = 5'h18;
   localparam logic [4:0]  SUB_DIAG       = 5'h1c;

   // ctrl fields and diagnosis bit positions
   localparam int          CTRL_DX_BIT    = 0;
   localparam int          CTRL_HOLD_BIT  = 1;
   localparam int          CTRL_PDIAG_BIT = 2;
   localparam int          COMM_DIAG_BIT  = 2;
   localparam int          MOD_DIAG_BIT   = 6;

   // parameter selectors
   typedef enum logic [7:0] {
      SEL_IGNORE = 8'h00,
      SEL_EMIS   = 8'h01,
      SEL_LASER  = 8'h02,
      SEL_BG     = 8'h03,
      SEL_AVG    = 8'h04,
      SEL_PEAK   = 8'h05,
      SEL_VALLEY = 8'h06,
      SEL_SETPT  = 8'h07
   } fpm_sel_t;

   localparam logic [15:0] LASER_OFF      = 16'h0000;
   localparam logic [15:0] LASER_ON       = 16'h0001;
   localparam logic [15:0] LASER_FLASH    = 16'h0002;
   localparam logic [15:0] EMIS_MIN       = 16'h0064;
   localparam logic [15:0] EMIS_MAX       = 16'h044c;
   localparam logic [15:0] RST_EMIS       = 16'h03b6;
   localparam logic [15:0] RST_BG         = 16'h0017;
   localparam logic [15:0] RST_SETPT      = 16'h01f4;
   localparam logic [7:0]  IOPS_GOOD      = 8'h80;
   localparam logic [7:0]  IOPS_BAD       = 8'h00;

   typedef struct packed {
      logic [15:0] emis;
      logic [1:0]  laser;
      logic [15:0] bg;
      logic [15:0] avg;
      logic [15:0] peak;
      logic [15:0] valley;
      logic [15:0] setpt;
   } fpm_param_t;

   typedef struct packed {
      logic [31:0] obj;
      logic [31:0] intern;
   } fpm_temp_t;

   // host-side bus outputs
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } fpm_ahb_rsp_t;

endpackage : fpm_pkg

/* File: testbench/fpm_ctrl_model.sv */
/* fieldbus controller model: single-word ahb-lite master and frame sender.
 assumes hready is the mapper's hreadyout and every call starts just after a rising edge. */
`timescale 1ns/1ps
module fpm_ctrl_model
   import fpm_pkg::*;
(
   input  wire logic    hclk,
   input  fpm_ahb_rsp_t ahb_rsp,
   output logic         hsel,
   output logic [31:0]  haddr,
   output logic [1:0]   htrans,
   output logic         hwrite,
   output logic [2:0]   hsize,
   output logic [31:0]  hwdata
);
   // idle bus from time zero
   initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

   // one transfer; no wait count assumed, the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      r = ahb_rsp.hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask

   // value frame, then back to the ignore selector so nothing changes by accident
   task automatic frame(input int m, input logic [7:0] s, input logic [15:0] v);
      logic [11:0] a;
      a = OFS_MOD_BASE + MOD_STRIDE * 12'(m) + {7'h0, SUB_OUT};
      wr(a, {8'h00, s, v});
      wr(a, 32'h0);
   endtask
endmodule // fpm_ctrl_model

/* File: testbench/fpm_mapper_monitor.sv */
/* checker for the process-data mapper, bound to its ports.
 assumes single word transfers with the mapper as the only slave. */
`timescale 1ns/1ps
module fpm_mapper_monitor
   import fpm_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   input  fpm_ahb_rsp_t             ahb_rsp,
   input  wire logic [NUM_MOD-1:0]  mod_comm_fail,
   input  fpm_param_t [NUM_MOD-1:0] mod_param,
   input  wire logic [NUM_MOD-1:0]  param_upd,
   input  wire logic                problem_ind
);
   logic        dp_wr, dp_rd, dp_out;
   logic [11:0] dp_addr;
   logic [2:0]  ctrl_q, q_mod;
   logic [7:0]  den_q, sel;
   logic [15:0] q_val;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // data phase of each accepted transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr   <= 1'b0;
         dp_rd   <= 1'b0;
         dp_addr <= 12'h000;
      end else if (hready) begin
         dp_wr   <= hsel && htrans[1] && hwrite;
         dp_rd   <= hsel && htrans[1] && !hwrite;
         dp_addr <= haddr[11:0];
      end
   end

   // shadow of control and enable registers, seen from the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= 3'h0;
         den_q  <= 8'h00;
      end else if (dp_wr && dp_addr == OFS_CTRL) begin
         ctrl_q <= hwdata[2:0];
      end else if (dp_wr && dp_addr == OFS_DIAG_EN) begin
         den_q  <= hwdata[7:0];
      end
   end

   // frame target kept one cycle for the update check
   always_ff @(posedge hclk) begin
      q_mod <= dp_addr[7:5];
      q_val <= hwdata[15:0];
   end

   assign dp_out = dp_wr && dp_addr[11:8] == 4'h1 && dp_addr[4:0] == SUB_OUT;
   assign sel    = hwdata[23:16];

   a_bus_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
      else $error("slave stalled or answered with an error");
   a_ctrl_read: assert property (dp_rd && dp_addr == OFS_CTRL |-> ahb_rsp.hrdata[2:0] == ctrl_q)
      else $error("control read does not return written value");
   a_upd_cause: assert property (param_upd != 8'h00 |->
      $past(dp_out) && $past(ctrl_q[0]) && param_upd == (8'h01 << q_mod))
      else $error("parameter update without a matching frame");
   a_sel_zero: assert property (dp_out && sel == 8'h00 |=> param_upd == 8'h00)
      else $error("ignore selector changed a parameter");
   a_sel_range: assert property (dp_out && sel > 8'h07 |=> param_upd == 8'h00)
      else $error("unknown selector changed a parameter");
   a_laser_bad: assert property (dp_out && sel == 8'h02 && hwdata[15:0] > LASER_FLASH
      |=> param_upd == 8'h00) else $error("bad laser value accepted");
   a_emis_apply: assert property (dp_out && ctrl_q[0] && sel == 8'h01
      && hwdata[15:0] >= EMIS_MIN && hwdata[15:0] <= EMIS_MAX
      |=> param_upd[q_mod] && mod_param[q_mod].emis == q_val)
      else $error("valid emissivity not applied");
   a_emis_over: assert property (dp_out && sel == 8'h01 && hwdata[15:0] > EMIS_MAX
      |=> $stable(mod_param)) else $error("emissivity above range applied");
   a_problem_flag: assert property (ctrl_q[2] && (mod_comm_fail & den_q) != 8'h00
      |-> ##[1:3] problem_ind) else $error("problem flag missing on module fault");
endmodule // fpm_mapper_monitor

bind fpm_mapper fpm_mapper_monitor fpm_mapper_monitor_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .ahb_rsp(ahb_rsp), .mod_comm_fail(mod_comm_fail),
   .mod_param(mod_param), .param_upd(param_upd), .problem_ind(problem_ind));

/* File: testbench/fpm_mapper_tb.sv */
/* self-checking bench for the process-data mapper.
 assumes the controller model drives the bus and the monitor is bound. */
`timescale 1ns/1ps
module fpm_mapper_tb
   import fpm_pkg::*;
;
   logic                     hclk, hresetn, hsel, hwrite, trigger_in;
   logic [31:0]              haddr, hwdata, station_temp, v;
   logic [1:0]               htrans;
   logic [2:0]               hsize;
   fpm_ahb_rsp_t             ahb_rsp;
   fpm_temp_t [NUM_MOD-1:0]  mod_temp;
   logic [NUM_MOD-1:0]       mod_comm_fail, mod_ext_err, param_upd;
   fpm_param_t [NUM_MOD-1:0] mod_param, exp_p;
   logic                     problem_ind, diag_alarm, station_problem;
   int                       errors, comparisons, n_alarm, n_sp, snap;

   fpm_mapper fpm_mapper_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(ahb_rsp.hreadyout), .ahb_rsp(ahb_rsp), .trigger_in(trigger_in),
      .station_temp(station_temp), .mod_temp(mod_temp), .mod_comm_fail(mod_comm_fail),
      .mod_ext_err(mod_ext_err), .mod_param(mod_param), .param_upd(param_upd),
      .problem_ind(problem_ind), .diag_alarm(diag_alarm), .station_problem(station_problem));

   fpm_ctrl_model ctrl_i (.hclk(hclk), .ahb_rsp(ahb_rsp), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 125 mhz clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // count alarm pulses, both are one cycle wide
   always @(posedge hclk) begin
      if (diag_alarm === 1'b1) n_alarm++;
      if (station_problem === 1'b1) n_sp++;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chkp(input fpm_param_t [NUM_MOD-1:0] g, input fpm_param_t [NUM_MOD-1:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t parameter set differs", $time);
      end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      ctrl_i.rd(a, v);
      chk(v, e);
   endtask

   // send a frame and track which field it should change
   task automatic send(input int m, input logic [7:0] s, input logic [15:0] x, input bit ok);
      ctrl_i.frame(m, s, x);
      if (ok) begin
         case (s)
            SEL_EMIS:   exp_p[m].emis = x;
            SEL_LASER:  exp_p[m].laser = x[1:0];
            SEL_BG:     exp_p[m].bg = x;
            SEL_AVG:    exp_p[m].avg = x;
            SEL_PEAK:   exp_p[m].peak = x;
            SEL_VALLEY: exp_p[m].valley = x;
            default:    exp_p[m].setpt = x;
         endcase
      end
      chkp(mod_param, exp_p);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog, far beyond the roughly 150 cycles the tests take
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      end_of_test();
   end

   initial begin
      hresetn       = 1'b0;
      trigger_in    = 1'b1;
      station_temp  = 32'h41c8_80a5;
      mod_comm_fail = 8'h00;
      mod_ext_err   = 8'h00;
      for (int i = 0; i < NUM_MOD; i++) begin
         mod_temp[i] = {32'h4200_0000 + 32'(i), 32'h4100_0000 + 32'(i)};
         exp_p[i]    = {RST_EMIS, 2'b00, RST_BG, 48'h0, RST_SETPT};
      end
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chkp(mod_param, exp_p);
      send(0, SEL_EMIS, 16'd500, 0);
      ctrl_i.wr(OFS_CTRL, 32'h5);
      rdc(OFS_CTRL, 32'h5);
      rdc(12'h0fc, 32'h0);
      send(1, SEL_EMIS, 16'd100, 1);
      send(2, SEL_LASER, 16'h0002, 1);
      send(3, SEL_BG, 16'h0123, 1);
      send(4, SEL_AVG, 16'd9990, 1);
      send(5, SEL_PEAK, 16'd10, 1);
      send(6, SEL_VALLEY, 16'h0000, 1);
      send(7, SEL_SETPT, 16'h0abc, 1);
      send(0, SEL_EMIS, 16'd1100, 1);
      send(1, SEL_EMIS, 16'd99, 0);
      send(1, SEL_EMIS, 16'd1101, 0);
      send(2, SEL_LASER, 16'h0003, 0);
      send(2, SEL_LASER, 16'h0000, 1);
      send(3, SEL_IGNORE, 16'h0200, 0);
      send(3, 8'h08, 16'h0005, 0);
      rdc(OFS_COMM_W0, 32'h0141_c880);
      rdc(OFS_COMM_W1, 32'ha500_0000);
      rdc(OFS_COMM_TEMP, 32'h41c8_80a5);
      for (int i = 0; i < NUM_MOD; i++) begin
         rdc(OFS_MOD_BASE + MOD_STRIDE * 12'(i), 32'h4200_0000 + 32'(i));
         rdc(OFS_MOD_BASE + MOD_STRIDE * 12'(i) + 12'h4, 32'h4100_0000 + 32'(i));
      end
      trigger_in <= 1'b0;
      repeat (2) @(posedge hclk);
      rdc(OFS_COMM_W0, 32'h0041_c880);
      // fault on module 3 with forwarding enabled
      ctrl_i.wr(OFS_DIAG_EN, 32'h0000_00ff);
      mod_comm_fail <= 8'h08;
      mod_ext_err   <= 8'h01;
      repeat (4) @(posedge hclk);
      chk({31'h0, problem_ind}, 32'h1);
      rdc(OFS_MOD_FAIL, 32'h8);
      ctrl_i.rd(OFS_COMM_DIAG, v);
      chk(v & 32'h4, 32'h4);
      ctrl_i.rd(12'h17c, v);
      chk(v & 32'h40, 32'h40);
      rdc(12'h160, 32'h0);
      rdc(OFS_IOPS, 32'h0080_8080);
      rdc(OFS_IOPS_HI, 32'h8080_8080);
      rdc(OFS_CHAN_ERR, 32'h1);
      chk(32'(n_alarm != 0), 32'h1);
      chk(32'(n_sp != 0), 32'h1);
      // fault on module 5 with forwarding blocked raises no alarm
      mod_comm_fail <= 8'h00;
      mod_ext_err   <= 8'h00;
      ctrl_i.wr(OFS_DIAG_EN, 32'h0);
      repeat (4) @(posedge hclk);
      snap = n_alarm;
      mod_comm_fail <= 8'h20;
      repeat (6) @(posedge hclk);
      chk(32'(n_alarm - snap), 32'h0);
      // hold-last-value mode keeps the image of a newly failing module
      ctrl_i.wr(OFS_CTRL, 32'h7);
      mod_comm_fail <= 8'h40;
      repeat (2) @(posedge hclk);
      rdc(12'h1c0, 32'h4200_0006);
      end_of_test();
   end
endmodule // fpm_mapper_tb
